// >>> svlp_map.vh
// Control table offsets, field positions, reset values and timing for the servo limit block
`ifndef SVLP_MAP_VH
`define SVLP_MAP_VH

// Register offsets
`define SVLP_OFS_PROTOCOL 8'h0d
`define SVLP_OFS_HOME 8'h14
`define SVLP_OFS_MOTION 8'h18
`define SVLP_OFS_HEAT 8'h1f
`define SVLP_OFS_VMAX 8'h20
`define SVLP_OFS_VMIN 8'h22
`define SVLP_OFS_DUTY 8'h24
`define SVLP_OFS_SPEED 8'h2c
`define SVLP_OFS_AMAX 8'h30
`define SVLP_OFS_AMIN 8'h34
`define SVLP_OFS_MASK 8'h3f
`define SVLP_OFS_DRIVE 8'h40
`define SVLP_OFS_LAMP 8'h41
// Offsets below this one are nonvolatile configuration
`define SVLP_OFS_VOLATILE 8'h40

// Fault bit positions, shared by mask and flags
`define SVLP_BIT_VOLT 0
`define SVLP_BIT_HEAT 2
`define SVLP_BIT_ENC 3
`define SVLP_BIT_SHOCK 4
`define SVLP_BIT_LOAD 5
`define SVLP_BIT_HW 7
`define SVLP_MASK_USED 8'h3d

// Protocol codes and operating modes
`define SVLP_PROTO_V1 8'h01
`define SVLP_PROTO_V2 8'h02
`define SVLP_MODE_SINGLE 8'h03
`define SVLP_MODE_MULTI 8'h04

// Value ranges
`define SVLP_HOME_LIM 32'sd1044479
`define SVLP_HOME_SINGLE_LIM 32'sd1024
`define SVLP_SPEED_MAX 32'sd1023
`define SVLP_HEAT_MAX 32'sd100
`define SVLP_VOLT_MIN 32'sd60
`define SVLP_VOLT_MAX 32'sd140
`define SVLP_DUTY_MAX 32'sd885
`define SVLP_ANGLE_MAX 32'sd4095
`define SVLP_TURN_BITS 12

// Reset values
`define SVLP_RST_PROTOCOL 8'h02
`define SVLP_RST_HOME 32'h00000000
`define SVLP_RST_MOTION 32'h0000000a
`define SVLP_RST_HEAT 8'h50
`define SVLP_RST_VMAX 16'h008c
`define SVLP_RST_VMIN 16'h003c
`define SVLP_RST_DUTY 16'h0375
`define SVLP_RST_SPEED 32'h000003ff
`define SVLP_RST_AMAX 32'h00000fff
`define SVLP_RST_AMIN 32'h00000000
`define SVLP_RST_MASK 8'h34

// Timing
`define SVLP_CLK_MHZ 200
`define SVLP_ALARM_PERIOD_MS 1000
`define SVLP_FLICK_MS 100
`define SVLP_MS_CYC(ms) ((ms) * 1000 * `SVLP_CLK_MHZ)

`endif

// >>> svlp_regs.v
// Servo configuration registers, fault protection and indicator lamp control
`include "svlp_map.vh"

module svlp_regs #(
    parameter ALARM_CYC = `SVLP_MS_CYC(`SVLP_ALARM_PERIOD_MS), // Shutdown blink period
    parameter FLICK_CYC = `SVLP_MS_CYC(`SVLP_FLICK_MS) // Boot/reset flicker half period
) (
    input wire clk, // 200 MHz clock
    input wire reset_n, // Async reset, active low
    input wire reg_wr, // Register write strobe
    input wire reg_rd, // Register read strobe
    input wire [7:0] reg_addr, // Register start offset
    input wire [31:0] reg_wdata, // Write value, low bits used
    output reg [31:0] reg_rdata, // Read value
    output reg reg_ack, // Access accepted pulse
    output reg reg_refused, // Access refused pulse
    input wire [7:0] op_mode, // Operating mode code
    input wire reverse_dir, // Reverse direction setting
    input wire signed [31:0] actual_position, // Sensed position, counts
    input wire signed [31:0] measured_speed, // Measured speed, 0.229 rpm units
    input wire [7:0] temperature, // Internal temperature, degrees
    input wire [15:0] supply_voltage, // Supply, 0.1 V units
    input wire overload_fault, // Persistent overload seen
    input wire shock_fault, // Electrical shock or low power
    input wire encoder_fault, // Encoder malfunction
    input wire reboot_cmd, // Reboot request pulse
    input wire factory_reset, // Factory reset pulse
    input wire boot_mode, // Boot mode level
    input wire duty_req, // Target duty request strobe
    input wire [15:0] duty_target, // Requested duty
    input wire speed_req, // Target speed request strobe
    input wire [31:0] speed_target, // Requested speed
    input wire angle_req, // Target angle request strobe
    input wire signed [31:0] angle_target, // Requested angle
    output reg signed [31:0] reported_position, // Position seen by host
    output reg moving, // In-motion flag
    output reg [7:0] fault_flags, // Current fault state
    output reg [7:0] status_error, // Error field for status replies
    output reg drive_enable, // Motor drive on
    output reg [15:0] duty_cmd, // Accepted duty, zero when off
    output reg [31:0] speed_cmd, // Accepted target speed
    output reg signed [31:0] angle_cmd, // Accepted target angle
    output reg target_refused, // Target request refused pulse
    output reg lamp // Indicator lamp drive
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Signed inclusive range test shared by the write value checks and the angle and adjust windows
    function in_range;
        input signed [31:0] v;
        input signed [31:0] lo;
        input signed [31:0] hi;
        begin
            in_range = (v >= lo) && (v <= hi);
        end
    endfunction

    // Treat a 32-bit unsigned field as signed for range tests
    function signed [31:0] as_signed;
        input [31:0] v;
        begin
            as_signed = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control table storage

    reg [7:0] protocol_select;
    reg signed [31:0] home_adjust;
    reg [31:0] motion_threshold;
    reg [7:0] heat_ceiling;
    reg [15:0] supply_upper_bound;
    reg [15:0] supply_lower_bound;
    reg [15:0] duty_ceiling;
    reg [31:0] speed_ceiling;
    reg [31:0] angle_upper_bound;
    reg [31:0] angle_lower_bound;
    reg [7:0] fault_cutoff_mask;
    reg drive_output_on;
    reg indicator_lamp;
    reg shutdown; // Latched until reboot
    reg drive_turned_on; // One-shot after enable write

    wire single_turn = (op_mode == `SVLP_MODE_SINGLE);
    wire signed [31:0] wval = reg_wdata;
    wire nonvolatile = (reg_addr < `SVLP_OFS_VOLATILE);
    wire wide_reg = (reg_addr == `SVLP_OFS_HOME) || (reg_addr == `SVLP_OFS_MOTION) ||
                    (reg_addr == `SVLP_OFS_SPEED) || (reg_addr == `SVLP_OFS_AMAX) ||
                    (reg_addr == `SVLP_OFS_AMIN);

    ////////////////////////////////////////////////////////////////////////
    // Access decode: mapped offset, protocol region and lock checks

    reg mapped;
    reg value_ok;
    always @* begin
        mapped = 1'b1;
        value_ok = 1'b1;
        case (reg_addr)
            `SVLP_OFS_PROTOCOL: value_ok = (reg_wdata[7:0] == `SVLP_PROTO_V1) ||
                                          (reg_wdata[7:0] == `SVLP_PROTO_V2);
            `SVLP_OFS_HOME: value_ok = in_range(wval, -`SVLP_HOME_LIM, `SVLP_HOME_LIM);
            `SVLP_OFS_MOTION: value_ok = in_range(wval, 32'sd0, `SVLP_SPEED_MAX);
            `SVLP_OFS_HEAT: value_ok = in_range(wval, 32'sd0, `SVLP_HEAT_MAX);
            `SVLP_OFS_VMAX,
            `SVLP_OFS_VMIN: value_ok = in_range(wval, `SVLP_VOLT_MIN, `SVLP_VOLT_MAX);
            `SVLP_OFS_DUTY: value_ok = in_range(wval, 32'sd0, `SVLP_DUTY_MAX);
            `SVLP_OFS_SPEED: value_ok = in_range(wval, 32'sd0, `SVLP_SPEED_MAX);
            `SVLP_OFS_AMAX,
            `SVLP_OFS_AMIN: value_ok = in_range(wval, 32'sd0, `SVLP_ANGLE_MAX);
            `SVLP_OFS_MASK: value_ok = (reg_wdata[31:8] == 24'h000000);
            `SVLP_OFS_DRIVE,
            `SVLP_OFS_LAMP: value_ok = (reg_wdata[31:1] == 31'h00000000);
            default: mapped = 1'b0;
        endcase
    end

    // Under version 1 the 32-bit fields are out of reach; the map itself never moves
    wire region_ok = !(protocol_select == `SVLP_PROTO_V1 && wide_reg);
    // Enabling drive freezes configuration; a refused write keeps the old value
    wire lock_ok = !(drive_output_on && nonvolatile);
    // After shutdown a write of 1 to the drive enable is refused
    wire drive_ok = !(reg_addr == `SVLP_OFS_DRIVE && reg_wdata[0] && shutdown);
    wire wr_take = reg_wr && mapped && region_ok && lock_ok && drive_ok && value_ok;
    wire rd_take = reg_rd && !reg_wr && mapped && region_ok;

    ////////////////////////////////////////////////////////////////////////
    // Fault detection, live each cycle

    reg [7:0] next_fault;
    always @* begin
        next_fault = 8'h00;
        next_fault[`SVLP_BIT_VOLT] = (supply_voltage > supply_upper_bound) ||
                                     (supply_voltage < supply_lower_bound);
        next_fault[`SVLP_BIT_HEAT] = (temperature > heat_ceiling);
        next_fault[`SVLP_BIT_ENC] = encoder_fault;
        next_fault[`SVLP_BIT_SHOCK] = shock_fault;
        next_fault[`SVLP_BIT_LOAD] = overload_fault;
        next_fault[`SVLP_BIT_HW] = |next_fault[6:0];
    end

    // Mask bit 0 is the voltage enable; fault bits line up with mask bits
    wire trip = |(next_fault[6:0] & fault_cutoff_mask[6:0]);

    ////////////////////////////////////////////////////////////////////////
    // Register writes, shutdown latch and reboot

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            protocol_select <= `SVLP_RST_PROTOCOL;
            home_adjust <= `SVLP_RST_HOME;
            motion_threshold <= `SVLP_RST_MOTION;
            heat_ceiling <= `SVLP_RST_HEAT;
            supply_upper_bound <= `SVLP_RST_VMAX;
            supply_lower_bound <= `SVLP_RST_VMIN;
            duty_ceiling <= `SVLP_RST_DUTY;
            speed_ceiling <= `SVLP_RST_SPEED;
            angle_upper_bound <= `SVLP_RST_AMAX;
            angle_lower_bound <= `SVLP_RST_AMIN;
            fault_cutoff_mask <= `SVLP_RST_MASK;
            drive_output_on <= 1'b0;
            indicator_lamp <= 1'b0;
            shutdown <= 1'b0;
            drive_turned_on <= 1'b0;
        end else begin
            drive_turned_on <= 1'b0;
            if (wr_take) begin
                case (reg_addr)
                    `SVLP_OFS_PROTOCOL: protocol_select <= reg_wdata[7:0];
                    `SVLP_OFS_HOME: home_adjust <= wval;
                    `SVLP_OFS_MOTION: motion_threshold <= reg_wdata;
                    `SVLP_OFS_HEAT: heat_ceiling <= reg_wdata[7:0];
                    `SVLP_OFS_VMAX: supply_upper_bound <= reg_wdata[15:0];
                    `SVLP_OFS_VMIN: supply_lower_bound <= reg_wdata[15:0];
                    `SVLP_OFS_DUTY: duty_ceiling <= reg_wdata[15:0];
                    `SVLP_OFS_SPEED: speed_ceiling <= reg_wdata;
                    `SVLP_OFS_AMAX: angle_upper_bound <= reg_wdata;
                    `SVLP_OFS_AMIN: angle_lower_bound <= reg_wdata;
                    `SVLP_OFS_MASK: fault_cutoff_mask <= reg_wdata[7:0] & `SVLP_MASK_USED;
                    `SVLP_OFS_DRIVE: begin
                        drive_output_on <= reg_wdata[0];
                        drive_turned_on <= reg_wdata[0] & ~drive_output_on;
                    end
                    `SVLP_OFS_LAMP: indicator_lamp <= reg_wdata[0];
                    default: ;
                endcase
            end
            // Trip wins over any write in the same cycle, so drive cannot slip back on
            if (trip) begin
                shutdown <= 1'b1;
                drive_output_on <= 1'b0;
                drive_turned_on <= 1'b0;
            end else if (reboot_cmd) begin
                shutdown <= 1'b0;
                drive_output_on <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port and access answers

    reg [31:0] rd_mux;
    always @* begin
        case (reg_addr)
            `SVLP_OFS_PROTOCOL: rd_mux = {24'h000000, protocol_select};
            `SVLP_OFS_HOME: rd_mux = home_adjust;
            `SVLP_OFS_MOTION: rd_mux = motion_threshold;
            `SVLP_OFS_HEAT: rd_mux = {24'h000000, heat_ceiling};
            `SVLP_OFS_VMAX: rd_mux = {16'h0000, supply_upper_bound};
            `SVLP_OFS_VMIN: rd_mux = {16'h0000, supply_lower_bound};
            `SVLP_OFS_DUTY: rd_mux = {16'h0000, duty_ceiling};
            `SVLP_OFS_SPEED: rd_mux = speed_ceiling;
            `SVLP_OFS_AMAX: rd_mux = angle_upper_bound;
            `SVLP_OFS_AMIN: rd_mux = angle_lower_bound;
            `SVLP_OFS_MASK: rd_mux = {24'h000000, fault_cutoff_mask};
            `SVLP_OFS_DRIVE: rd_mux = {31'h00000000, drive_output_on};
            `SVLP_OFS_LAMP: rd_mux = {31'h00000000, indicator_lamp};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
            reg_ack <= 1'b0;
            reg_refused <= 1'b0;
        end else begin
            reg_ack <= wr_take || rd_take;
            reg_refused <= (reg_wr && !wr_take) || (reg_rd && !reg_wr && !rd_take);
            if (rd_take) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position, motion and fault reporting

    // Out-of-window adjust is dropped in single-turn mode; sign never follows direction
    wire adj_valid = !single_turn ||
                     in_range(home_adjust, -`SVLP_HOME_SINGLE_LIM, `SVLP_HOME_SINGLE_LIM);
    wire signed [31:0] adj_used = adj_valid ? home_adjust : 32'sd0;
    wire signed [31:0] speed_abs = measured_speed[31] ? -measured_speed : measured_speed;
    reg turn_wrap; // Report within one rotation after drive-on in single-turn mode
    wire signed [31:0] pos_base = turn_wrap ?
        {{(32 - `SVLP_TURN_BITS){1'b0}}, actual_position[`SVLP_TURN_BITS-1:0]} : actual_position;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            turn_wrap <= 1'b0;
            reported_position <= 32'sd0;
            moving <= 1'b0;
            fault_flags <= 8'h00;
            status_error <= 8'h00;
            drive_enable <= 1'b0;
        end else begin
            if (drive_turned_on) begin
                turn_wrap <= single_turn;
            end else if (!drive_output_on) begin
                turn_wrap <= 1'b0;
            end
            reported_position <= pos_base + adj_used;
            moving <= (speed_abs > as_signed(motion_threshold));
            fault_flags <= {next_fault[7] | shutdown, next_fault[6:0]};
            status_error <= {(shutdown | trip), 7'h00};
            drive_enable <= drive_output_on && !trip && !shutdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Target requests checked against the ceilings

    wire angle_in = in_range(angle_target, as_signed(angle_lower_bound),
                             as_signed(angle_upper_bound));
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            duty_cmd <= 16'h0000;
            speed_cmd <= 32'h00000000;
            angle_cmd <= 32'sd0;
            target_refused <= 1'b0;
        end else begin
            target_refused <= (duty_req && (duty_target > duty_ceiling)) ||
                              (speed_req && (speed_target > speed_ceiling)) ||
                              (angle_req && single_turn && !angle_in);
            if (!drive_output_on || trip || shutdown) begin
                duty_cmd <= 16'h0000;
            end else if (duty_req && duty_target <= duty_ceiling) begin
                duty_cmd <= duty_target;
            end else if (duty_cmd > duty_ceiling) begin
                duty_cmd <= duty_ceiling;
            end
            if (speed_req && speed_target <= speed_ceiling) begin
                speed_cmd <= speed_target;
            end
            // The host is expected to stay inside the bounds; the check guards it in single-turn mode only
            if (angle_req && (!single_turn || angle_in)) begin
                angle_cmd <= angle_target;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator lamp patterns

    // Flicker sequences: one on boot, four on factory reset
    reg [2:0] flick_left;
    reg flick_phase;
    reg [31:0] flick_timer;
    reg [31:0] alarm_timer;
    wire flick_end = (flick_timer == FLICK_CYC - 1);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flick_left <= 3'd1;
            flick_phase <= 1'b1;
            flick_timer <= 32'h00000000;
        end else if (factory_reset) begin
            flick_left <= 3'd4;
            flick_phase <= 1'b1;
            flick_timer <= 32'h00000000;
        end else if (flick_left != 3'd0) begin
            flick_timer <= flick_end ? 32'h00000000 : flick_timer + 32'h00000001;
            if (flick_end) begin
                flick_phase <= ~flick_phase;
                if (!flick_phase) begin
                    flick_left <= flick_left - 3'd1;
                end
            end
        end
    end

    // Alarm blink runs one period per second, lit for the first half
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm_timer <= 32'h00000000;
        end else if (!shutdown || alarm_timer == ALARM_CYC - 1) begin
            alarm_timer <= 32'h00000000;
        end else begin
            alarm_timer <= alarm_timer + 32'h00000001;
        end
    end

    // Boot mode holds the lamp on; otherwise sequences, alarm, then the register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lamp <= 1'b0;
        end else if (boot_mode) begin
            lamp <= 1'b1;
        end else if (flick_left != 3'd0) begin
            lamp <= flick_phase;
        end else if (shutdown) begin
            lamp <= (alarm_timer < ALARM_CYC / 2);
        end else begin
            lamp <= indicator_lamp;
        end
    end

endmodule // svlp_regs

// >>> svlp_regs_properties.sv
// Port-level checks for the servo limit register block
module svlp_regs_properties (
    input wire clk, // Clock
    input wire reset_n, // Async reset, active low
    input wire reg_wr, // Write strobe
    input wire reg_rd, // Read strobe
    input wire reg_ack, // Accepted pulse
    input wire reg_refused, // Refused pulse
    input wire encoder_fault, // Encoder fault level
    input wire reboot_cmd, // Reboot pulse
    input wire boot_mode, // Boot mode level
    input wire [7:0] fault_flags, // Fault state
    input wire [7:0] status_error, // Status error field
    input wire drive_enable, // Drive on
    input wire [15:0] duty_cmd, // Duty output
    input wire lamp // Lamp drive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    // Access steps: request taken, then exactly one answer
    sequence s_taken; reg_wr || reg_rd; endsequence
    sequence s_answer; reg_ack ^ reg_refused; endsequence
    // A latched shutdown, no reboot now or last cycle (status lags the latch)
    sequence s_latched; status_error == 8'h80 && !reboot_cmd && !$past(reboot_cmd); endsequence
    chk_access_answer: assert property (s_taken |=> s_answer)
        else $error("access not answered once");
    chk_answer_cause: assert property (s_answer |-> $past(reg_wr || reg_rd))
        else $error("answer without request");
    chk_encoder_flag: assert property (encoder_fault |=> fault_flags[3] && fault_flags[7])
        else $error("encoder fault not flagged");
    chk_unused_bits: assert property (!fault_flags[6] && !fault_flags[1])
        else $error("unused fault bit set");
    chk_status_code: assert property (status_error == 8'h00 || status_error == 8'h80)
        else $error("bad status error code");
    chk_trip_off: assert property (status_error == 8'h80 |-> !drive_enable)
        else $error("drive on during shutdown");
    chk_drive_zero: assert property (!drive_enable |-> duty_cmd == 16'h0000)
        else $error("duty nonzero with drive off");
    chk_shutdown_hold: assert property (s_latched |=> status_error == 8'h80)
        else $error("shutdown left without reboot");
    chk_boot_lamp: assert property (boot_mode |=> lamp)
        else $error("lamp off in boot mode");
endmodule // svlp_regs_properties

bind svlp_regs svlp_regs_properties chk (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_ack(reg_ack), .reg_refused(reg_refused),
    .encoder_fault(encoder_fault), .reboot_cmd(reboot_cmd), .boot_mode(boot_mode),
    .fault_flags(fault_flags), .status_error(status_error), .drive_enable(drive_enable),
    .duty_cmd(duty_cmd), .lamp(lamp));

// >>> svlp_host.sv
// Host model issuing whole-register accesses to the device
module svlp_host (
    input wire clk, // Clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [7:0] reg_addr, // Offset
    output logic [31:0] reg_wdata, // Write value
    input wire [31:0] reg_rdata, // Read value
    input wire reg_ack, // Accepted
    input wire reg_refused // Refused
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end
    // One access; released lines show inverted values so stale data never passes
    task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        @(posedge clk) #1;
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        {reg_wr, reg_rd} = 2'b00;
        reg_addr = ~a;
        reg_wdata = ~d;
        ok = (reg_ack === 1'b1) && (reg_refused === 1'b0);
        q = reg_rdata;
    endtask
endmodule // svlp_host

// >>> svlp_regs_bench.sv
// Self-checking bench for the servo limit register block
module svlp_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, reverse_dir, reboot_cmd, factory_reset, boot_mode, reg_wr, reg_rd;
    logic overload_fault, shock_fault, encoder_fault, duty_req, speed_req, angle_req;
    logic reg_ack, reg_refused, moving, drive_enable, target_refused, lamp, ok;
    logic [7:0] op_mode, temperature, fault_flags, status_error, reg_addr;
    logic [15:0] supply_voltage, duty_target, duty_cmd;
    logic signed [31:0] actual_position, measured_speed, angle_target, reported_position;
    logic signed [31:0] angle_cmd;
    logic [31:0] speed_target, speed_cmd, reg_rdata, reg_wdata, q;
    int bad_count, checks, cyc, ons, rises;
    svlp_regs #(.ALARM_CYC(20), .FLICK_CYC(4)) dut (.*);
    svlp_host host (.*);
    ////////////////////////////////////////
    // 200 MHz clock and a cycle ceiling against hangs
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            stop_test();
        end
    end
    ////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Register access with its expected acceptance
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        host.access(w, a, d, q, ok);
        cmp("accept", {31'h0, e}, {31'h0, ok});
    endtask
    // Target request of kind 0 duty, 1 speed, 2 angle, after one idle edge
    task automatic tgt(input int k, input logic [31:0] v, input logic e);
        tick(1);
        {duty_req, speed_req, angle_req} = {k == 0, k == 1, k == 2};
        {duty_target, speed_target, angle_target} = {v[15:0], v, v};
        tick(1);
        {duty_req, speed_req, angle_req} = 3'b000;
        cmp("target refused", {31'h0, !e}, {31'h0, target_refused});
    endtask
    // Lamp on-cycles and rising edges over n cycles
    task automatic watch(input int n);
        logic p;
        {ons, rises, p} = '0;
        repeat (n) begin
            tick(1);
            ons += lamp;
            rises += (lamp && !p);
            p = lamp;
        end
    endtask
    ////////////////////////////////////////
    task automatic t_regs;
        logic [7:0] a [6] = '{8'h0d, 8'h40, 8'h41, 8'h3f, 8'h24, 8'h1f};
        logic [31:0] e [6] = '{32'h2, 32'h0, 32'h0, 32'h34, 32'h375, 32'h50};
        logic [7:0] ba [6] = '{8'h1f, 8'h20, 8'h22, 8'h24, 8'h2c, 8'h14};
        logic [31:0] bv [6] = '{32'h65, 32'h8d, 32'h3b, 32'h376, 32'h400, 32'hff100};
        for (int i = 0; i < 6; i++) begin
            rw(1'b0, a[i], 32'h0, 1'b1);
            cmp("reset value", e[i], q);
            rw(1'b1, ba[i], bv[i], 1'b0);
        end
        rw(1'b0, 8'h24, 32'h0, 1'b1);
        cmp("duty ceiling kept", 32'h375, q);
        rw(1'b0, 8'h01, 32'h0, 1'b0);
        rw(1'b1, 8'h0d, 32'h3, 1'b0);
        rw(1'b1, 8'h0d, 32'h1, 1'b1);
        rw(1'b0, 8'h14, 32'h0, 1'b0);
        rw(1'b0, 8'h1f, 32'h0, 1'b1);
        rw(1'b1, 8'h0d, 32'h2, 1'b1);
        rw(1'b0, 8'h14, 32'h0, 1'b1);
        rw(1'b1, 8'h41, 32'h1, 1'b1);
        tick(2);
        cmp("lamp", 32'h1, {31'h0, lamp});
        rw(1'b1, 8'h41, 32'h0, 1'b1);
        $display("register test done");
    endtask
    task automatic t_targets;
        rw(1'b1, 8'h40, 32'h1, 1'b1);
        tgt(0, 32'h376, 1'b0);
        tgt(0, 32'h375, 1'b1);
        cmp("duty", 32'h375, {16'h0, duty_cmd});
        tgt(1, 32'h400, 1'b0);
        tgt(1, 32'h3ff, 1'b1);
        cmp("speed", 32'h3ff, speed_cmd);
        tgt(2, 32'h1388, 1'b1);
        op_mode = 8'h03;
        tgt(2, 32'h1388, 1'b0);
        tgt(2, 32'hfff, 1'b1);
        cmp("angle", 32'hfff, angle_cmd);
        rw(1'b1, 8'h1f, 32'h50, 1'b0);
        rw(1'b1, 8'h40, 32'h0, 1'b1);
        rw(1'b1, 8'h1f, 32'h50, 1'b1);
        $display("target test done");
    endtask
    task automatic t_motion;
        logic [31:0] s [4] = '{32'hfffffff5, 32'ha, 32'hb, 32'hfffffff6};
        op_mode = 8'h04;
        rw(1'b1, 8'h14, 32'hfffffffb, 1'b1);
        tick(2);
        cmp("position", 32'h3e3, reported_position);
        rw(1'b1, 8'h14, 32'h7d0, 1'b1);
        tick(2);
        cmp("position", 32'hbb8, reported_position);
        op_mode = 8'h03;
        tick(2);
        cmp("position", 32'h3e8, reported_position);
        for (int i = 0; i < 4; i++) begin
            measured_speed = s[i];
            tick(2);
            cmp("moving", {31'h0, i[0] == 0}, {31'h0, moving});
        end
        $display("motion test done");
    endtask
    task automatic t_shutdown;
        rw(1'b1, 8'h3f, 32'hff, 1'b1);
        rw(1'b0, 8'h3f, 32'h0, 1'b1);
        cmp("mask", 32'h3d, q);
        rw(1'b1, 8'h3f, 32'h5, 1'b1);
        rw(1'b1, 8'h40, 32'h1, 1'b1);
        supply_voltage = 16'h0096;
        tick(2);
        cmp("flags", 32'h81, {24'h0, fault_flags});
        cmp("status", 32'h80, {24'h0, status_error});
        rw(1'b0, 8'h40, 32'h0, 1'b1);
        cmp("drive reg", 32'h0, q);
        supply_voltage = 16'h0078;
        rw(1'b1, 8'h40, 32'h1, 1'b0);
        watch(40);
        cmp("blink", 32'd20, ons);
        reboot_cmd = 1'b1;
        tick(1);
        reboot_cmd = 1'b0;
        rw(1'b1, 8'h40, 32'h1, 1'b1);
        temperature = 8'h51;
        tick(2);
        cmp("flags", 32'h84, {24'h0, fault_flags});
        cmp("drive", 32'h0, {31'h0, drive_enable});
        temperature = 8'h19;
        encoder_fault = 1'b1;
        tick(2);
        {encoder_fault, reboot_cmd} = 2'b01;
        tick(1);
        reboot_cmd = 1'b0;
        factory_reset = 1'b1;
        tick(1);
        factory_reset = 1'b0;
        watch(40);
        cmp("flickers", 32'd4, rises);
        boot_mode = 1'b1;
        tick(3);
        boot_mode = 1'b0;
        $display("shutdown test done");
    endtask
    ////////////////////////////////////////
    // Inputs settled at time zero, reset held five cycles
    initial begin
        {reset_n, reverse_dir, reboot_cmd, factory_reset, boot_mode, overload_fault} = '0;
        {shock_fault, encoder_fault, duty_req, speed_req, angle_req, duty_target} = '0;
        {actual_position, measured_speed, angle_target, speed_target} = '0;
        {op_mode, temperature, supply_voltage} = {8'h04, 8'h19, 16'h0078};
        {bad_count, checks, cyc} = '0;
        actual_position = 32'h3e8;
        reverse_dir = 1'b1;
        tick(5);
        reset_n = 1'b1;
        tick(20);
        t_regs();
        t_targets();
        t_motion();
        t_shutdown();
        stop_test();
    end
endmodule // svlp_regs_bench
